// ### rtsp_timer_unit.sv
// Timer unit: reload timer pair, start synchronisation, counter pin.
`timescale 1ns/1ps
`default_nettype none
module rtsp_timer_unit #(
    parameter int PRESC_DIV_FAST = rtsp_pkg::RTSP_PRESC_DIV_FAST,
    parameter int PRESC_DIV_SLOW = rtsp_pkg::RTSP_PRESC_DIV_SLOW
) (
    input  wire logic mclk,                       // Instruction clock.
    input  wire logic arst_n,                     // Reset, active low.
    input  wire logic [3:0] first_timer_control_register,  // Sync/run/psc.
    input  wire logic [3:0] second_timer_control_register, // Src/stop/run.
    input  wire logic [1:0] pin_function_register,         // Pin function.
    input  wire logic [2:0] interrupt_pin_control_register, // Edge setup.
    input  wire logic [1:0] interrupt_select_register,     // Irq enables.
    input  wire logic load_first_timer_and_reload_instr,   // Load strobe.
    input  wire logic write_first_reload_instr,            // Reload strobe.
    input  wire logic load_second_timer_and_reload_instr,  // Load strobe.
    input  wire logic [rtsp_pkg::RTSP_TW-1:0] instr_data,  // Load value.
    input  wire logic skip_on_first_timer_flag,   // Skip test strobe.
    input  wire logic skip_on_second_timer_flag,  // Skip test strobe.
    input  wire logic first_timer_int_ack,        // Interrupt taken.
    input  wire logic second_timer_int_ack,       // Interrupt taken.
    input  wire logic int_pin,                    // External interrupt pin.
    input  wire logic counter_pin_in,             // Counter pin level.
    output logic [rtsp_pkg::RTSP_TW-1:0] first_timer_count,  // Count.
    output logic [rtsp_pkg::RTSP_TW-1:0] second_timer_count, // Count.
    output logic first_timer_underflow_flag,      // Request flag.
    output logic second_timer_underflow_flag,     // Request flag.
    output logic first_timer_irq,                 // Interrupt request.
    output logic second_timer_irq,                // Interrupt request.
    output logic skip_next,                       // Skip answer pulse.
    output logic counter_pin_out,                 // Pin output level.
    output logic counter_pin_oe,                  // Pin output enable.
    output logic sync_active                      // Sync circuit state.
);
    import rtsp_pkg::*;

    localparam logic [RTSP_PRESC_CW-1:0] PSC_FAST_LAST =
        RTSP_PRESC_CW'(PRESC_DIV_FAST - 1);
    localparam logic [RTSP_PRESC_CW-1:0] PSC_SLOW_LAST =
        RTSP_PRESC_CW'(PRESC_DIV_SLOW - 1);

    typedef struct packed {
        logic [RTSP_PRESC_CW-1:0] psc_cnt;
        logic                     psc_tick;
        logic                     int_prev;
        logic                     cpin_prev;
        logic                     sync_on;
        logic                     flag1;
        logic                     flag2;
        logic                     irq1;
        logic                     irq2;
        logic                     skip;
        logic                     pin_out;
        logic                     pin_oe;
    } rtsp_top_state_t;

    rtsp_top_state_t s;
    rtsp_top_state_t next_s;

    logic                 int_lvl;
    logic                 cpin_lvl;
    logic                 int_edge;
    logic                 cpin_fall;
    logic                 t1_tick;
    logic                 t2_tick;
    logic                 t1_uf;
    logic                 t2_uf;
    logic                 autostop;
    logic [RTSP_TW-1:0]   t1_cnt;
    logic [RTSP_TW-1:0]   t2_cnt;
    rtsp_src_t            t2_src;

    // Both pins pass four flip-flops before any edge logic sees them.
    rtsp_pin_filter u_int_filter (
        .mclk   (mclk),
        .arst_n (arst_n),
        .pin    (int_pin),
        .level  (int_lvl)
    );

    rtsp_pin_filter u_cpin_filter (
        .mclk   (mclk),
        .arst_n (arst_n),
        .pin    (counter_pin_in),
        .level  (cpin_lvl)
    );

    // Edge selection on the filtered interrupt pin level.
    always_comb begin
        if (interrupt_pin_control_register[RTSP_I1_BOTH]) begin
            int_edge = int_lvl != s.int_prev;
        end else if (interrupt_pin_control_register[RTSP_I1_POL]) begin
            int_edge = int_lvl && !s.int_prev;
        end else begin
            int_edge = !int_lvl && s.int_prev;
        end
    end

    // Count source routing. The first timer runs from the prescaler; while
    // the sync circuit is selected that source is gated by its state.
    assign cpin_fall = s.cpin_prev && !cpin_lvl;
    assign t1_tick   = s.psc_tick &&
        (!first_timer_control_register[RTSP_W1_SYNC_SEL] ||
         s.sync_on);
    assign autostop  = t1_uf &&
        second_timer_control_register[RTSP_W2_AUTOSTOP] &&
        first_timer_control_register[RTSP_W1_SYNC_SEL];
    assign t2_src    = rtsp_src_t'(second_timer_control_register[
        RTSP_W2_SRC_HI:RTSP_W2_SRC_LO]);

    // Second timer source multiplexer.
    always_comb begin
        unique case (t2_src)
            RTSP_SRC_T1UF:   t2_tick = t1_uf;
            RTSP_SRC_PRESC:  t2_tick = s.psc_tick;
            RTSP_SRC_PIN:    t2_tick = cpin_fall;
            RTSP_SRC_SYSCLK: t2_tick = 1'b1;
        endcase
    end

    rtsp_down_timer #(.WIDTH(RTSP_TW)) u_first_timer (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .run       (first_timer_control_register[RTSP_W1_T1_RUN]),
        .tick      (t1_tick),
        .load      (load_first_timer_and_reload_instr),
        .wr_reload (write_first_reload_instr),
        .data      (instr_data),
        .count     (t1_cnt),
        .underflow (t1_uf)
    );

    // The second timer has no separate reload write instruction.
    rtsp_down_timer #(.WIDTH(RTSP_TW)) u_second_timer (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .run       (second_timer_control_register[RTSP_W2_T2_RUN]),
        .tick      (t2_tick),
        .load      (load_second_timer_and_reload_instr),
        .wr_reload (1'b0),
        .data      (instr_data),
        .count     (t2_cnt),
        .underflow (t2_uf)
    );

    // Next-state logic for prescaler, sync circuit, flags and pin.
    always_comb begin
        next_s           = s;
        next_s.psc_tick  = 1'b0;
        next_s.int_prev  = int_lvl;
        next_s.cpin_prev = cpin_lvl;
        // A stopped prescaler restarts from zero, so the ratio is clean.
        if (!first_timer_control_register[RTSP_W1_PRUN]) begin
            next_s.psc_cnt = '0;
        end else if (s.psc_cnt == (first_timer_control_register[RTSP_W1_PDIV]
                     ? PSC_SLOW_LAST : PSC_FAST_LAST)) begin
            next_s.psc_cnt  = '0;
            next_s.psc_tick = 1'b1;
        end else begin
            next_s.psc_cnt = s.psc_cnt + 1'b1;
        end
        // A valid edge wins over an auto-stop in the same cycle.
        if (!interrupt_pin_control_register[RTSP_I1_EN]) begin
            next_s.sync_on = 1'b0;
        end else if (int_edge &&
                     first_timer_control_register[RTSP_W1_SYNC_SEL]) begin
            next_s.sync_on = 1'b1;
        end else if (autostop) begin
            next_s.sync_on = 1'b0;
        end
        // Flags: an underflow wins over an acknowledge or a skip.
        if (t1_uf) begin
            next_s.flag1 = 1'b1;
        end else if (first_timer_int_ack ||
                     (skip_on_first_timer_flag && s.flag1)) begin
            next_s.flag1 = 1'b0;
        end
        if (t2_uf) begin
            next_s.flag2 = 1'b1;
        end else if (second_timer_int_ack ||
                     (skip_on_second_timer_flag && s.flag2)) begin
            next_s.flag2 = 1'b0;
        end
        next_s.skip = (skip_on_first_timer_flag && s.flag1) ||
                      (skip_on_second_timer_flag && s.flag2);
        next_s.irq1 = next_s.flag1 &&
                      interrupt_select_register[RTSP_V1_T1];
        next_s.irq2 = next_s.flag2 &&
                      interrupt_select_register[RTSP_V1_T2];
        // Counter pin: halved underflow of the chosen timer.
        next_s.pin_oe = pin_function_register[RTSP_W6_FUNC];
        if (pin_function_register[RTSP_W6_OSEL] ? t2_uf : t1_uf) begin
            next_s.pin_out = !s.pin_out;
        end
    end

    // State register; reset clears flags, sync circuit and toggle.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{'0, 1'b0, RTSP_PIN_RST, RTSP_PIN_RST,
                   1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                   1'b0, 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign first_timer_count           = t1_cnt;
    assign second_timer_count          = t2_cnt;
    assign first_timer_underflow_flag  = s.flag1;
    assign second_timer_underflow_flag = s.flag2;
    assign first_timer_irq             = s.irq1;
    assign second_timer_irq            = s.irq2;
    assign skip_next                   = s.skip;
    assign counter_pin_out             = s.pin_out;
    assign counter_pin_oe              = s.pin_oe;
    assign sync_active                 = s.sync_on;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence seq_skip_hit;
        skip_on_first_timer_flag && s.flag1 && !t1_uf &&
        !skip_on_second_timer_flag;
    endsequence
    sequence seq_sync_armed;
        interrupt_pin_control_register[RTSP_I1_EN] &&
        first_timer_control_register[RTSP_W1_SYNC_SEL] && int_edge;
    endsequence

    AST_SKIP_CLEARS: assert property (
        seq_skip_hit |=> skip_next && !first_timer_underflow_flag)
        else $error("Taken skip did not clear the flag.");
    AST_FLAG_SET: assert property (
        t2_uf |=> second_timer_underflow_flag ##1
        (second_timer_underflow_flag || $past(second_timer_int_ack) ||
         $past(skip_on_second_timer_flag) || $past(t2_uf)))
        else $error("Underflow did not set the flag.");
    AST_IRQ_GATE: assert property (
        !interrupt_select_register[RTSP_V1_T1] |=> !first_timer_irq)
        else $error("Masked interrupt raised.");
    AST_SYNC_SET: assert property (
        seq_sync_armed |=> sync_active)
        else $error("Valid edge did not set the sync circuit.");
    AST_SYNC_DROP: assert property (
        !interrupt_pin_control_register[RTSP_I1_EN] |=> !sync_active)
        else $error("Sync circuit held with pin control off.");
    AST_AUTOSTOP: assert property (
        autostop && !int_edge |=> !sync_active)
        else $error("Auto-stop did not clear the sync circuit.");
    AST_NO_AUTOSTOP: assert property (
        sync_active && !first_timer_control_register[RTSP_W1_SYNC_SEL] &&
        interrupt_pin_control_register[RTSP_I1_EN] |=> sync_active)
        else $error("Auto-stop acted without sync selection.");
    AST_T1_GATED: assert property (
        first_timer_control_register[RTSP_W1_SYNC_SEL] && !s.sync_on
        |-> !t1_tick)
        else $error("First timer counted while sync circuit clear.");
    AST_PIN_TOGGLE: assert property (
        t1_uf && !pin_function_register[RTSP_W6_OSEL]
        |=> counter_pin_out != $past(counter_pin_out))
        else $error("Counter pin did not toggle on underflow.");
    AST_PSC_STOP: assert property (
        !first_timer_control_register[RTSP_W1_PRUN][*2] |-> !s.psc_tick)
        else $error("Prescaler ran while stopped.");
    AST_SRC_SYSCLK: assert property (
        t2_src == RTSP_SRC_SYSCLK |-> t2_tick)
        else $error("System clock source did not count.");
endmodule // rtsp_timer_unit
`default_nettype wire

// ### rtsp_pkg.sv
// Shared constants and types for the reload timer pair.
package rtsp_pkg;
    // Counter width of both timers.
    localparam int RTSP_TW = 8;
    // First timer control register bit positions.
    localparam int RTSP_W1_SYNC_SEL = 0;
    localparam int RTSP_W1_T1_RUN   = 1;
    localparam int RTSP_W1_PDIV     = 2;
    localparam int RTSP_W1_PRUN     = 3;
    // Second timer control register bit positions.
    localparam int RTSP_W2_SRC_LO   = 0;
    localparam int RTSP_W2_SRC_HI   = 1;
    localparam int RTSP_W2_AUTOSTOP = 2;
    localparam int RTSP_W2_T2_RUN   = 3;
    // Pin function register bit positions.
    localparam int RTSP_W6_FUNC = 0;
    localparam int RTSP_W6_OSEL = 1;
    // Interrupt pin control register bit positions.
    localparam int RTSP_I1_EN   = 0;
    localparam int RTSP_I1_BOTH = 1;
    localparam int RTSP_I1_POL  = 2;
    // Interrupt select register bit positions.
    localparam int RTSP_V1_T1 = 0;
    localparam int RTSP_V1_T2 = 1;
    // Prescaler division ratios in instruction clock cycles.
    localparam int RTSP_PRESC_DIV_FAST = 4;
    localparam int RTSP_PRESC_DIV_SLOW = 16;
    localparam int RTSP_PRESC_CW       = 5;
    // Values after reset.
    localparam logic [RTSP_TW-1:0] RTSP_CNT_RST = 8'h00;
    localparam logic               RTSP_PIN_RST = 1'h1;
    // Second timer count source codes.
    typedef enum logic [1:0] {
        RTSP_SRC_T1UF   = 2'h0,
        RTSP_SRC_PRESC  = 2'h1,
        RTSP_SRC_PIN    = 2'h2,
        RTSP_SRC_SYSCLK = 2'h3
    } rtsp_src_t;
endpackage

// ### rtsp_pin_filter.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module rtsp_pin_filter (
    input  wire logic mclk,    // Instruction clock.
    input  wire logic arst_n,  // Asynchronous reset, active low.
    input  wire logic pin,     // Raw pin level.
    output logic      level    // Filtered level.
);
    import rtsp_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } rtsp_flt_state_t;

    rtsp_flt_state_t s;
    rtsp_flt_state_t next_s;

    // The first stage feeds only the second; the level moves only once the
    // second and third stages agree, so a single-cycle glitch is ignored.
    always_comb begin
        next_s    = s;
        next_s.s1 = pin;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        if (s.s2 == s.s3) begin
            next_s.lvl = s.s3;
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{RTSP_PIN_RST, RTSP_PIN_RST, RTSP_PIN_RST, RTSP_PIN_RST};
        end else begin
            s <= next_s;
        end
    end

    assign level = s.lvl;
endmodule // rtsp_pin_filter
`default_nettype wire

// ### rtsp_down_timer.sv
// Down counter with reload register and underflow pulse.
`timescale 1ns/1ps
`default_nettype none
module rtsp_down_timer #(
    parameter int WIDTH = rtsp_pkg::RTSP_TW
) (
    input  wire logic             mclk,      // Instruction clock.
    input  wire logic             arst_n,    // Asynchronous reset, active low.
    input  wire logic             run,       // Counting enabled.
    input  wire logic             tick,      // Count source pulse.
    input  wire logic             load,      // Write counter and reload.
    input  wire logic             wr_reload, // Write reload register only.
    input  wire logic [WIDTH-1:0] data,      // Value to write.
    output logic      [WIDTH-1:0] count,     // Present count.
    output logic                  underflow  // One-cycle underflow pulse.
);
    import rtsp_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic [WIDTH-1:0] rld;
        logic             uf;
    } rtsp_tmr_state_t;

    rtsp_tmr_state_t s;
    rtsp_tmr_state_t next_s;

    // A load writes counter and reload together; a pulse at zero reloads.
    always_comb begin
        next_s    = s;
        next_s.uf = 1'b0;
        if (load) begin
            next_s.cnt = data;
            next_s.rld = data;
        end else begin
            if (wr_reload) begin
                next_s.rld = data;
            end
            if (run && tick) begin
                if (s.cnt == '0) begin
                    next_s.cnt = wr_reload ? data : s.rld;
                    next_s.uf  = 1'b1;
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{'0, '0, 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign count     = s.cnt;
    assign underflow = s.uf;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    AST_TMR_RELOAD: assert property (
        run && tick && !load && !wr_reload && s.cnt == '0
        |=> underflow && count == $past(s.rld))
        else $error("Timer did not reload at underflow.");
    AST_TMR_DECR: assert property (
        run && tick && !load && s.cnt != '0
        |=> !underflow && count == $past(s.cnt) - 1'b1)
        else $error("Timer did not count down on a pulse.");
    AST_TMR_LOAD: assert property (
        load |=> count == $past(data) && s.rld == $past(data))
        else $error("Load did not write counter and reload.");
    AST_TMR_HOLD: assert property (
        !(run && tick) && !load |=> $stable(count) && !underflow)
        else $error("Timer moved without a count pulse.");
endmodule // rtsp_down_timer
`default_nettype wire

// ### rtsp_cpu_model.sv
// CPU core model issuing the timers' load, skip and acknowledge instructions.
`timescale 1ns/1ps
`default_nettype none
module rtsp_cpu_model (
    input  wire logic                  mclk, // Instruction clock.
    output logic [3:0]                 w2,   // Second timer control.
    output logic                       ld2,  // Load strobe.
    output logic                       sk2,  // Skip strobe.
    output logic                       ack2, // Interrupt taken.
    output logic                       ld1,  // First timer load strobe.
    output logic                       wr1,  // First reload write strobe.
    output logic                       sk1,  // First skip strobe.
    output logic                       ack1, // First interrupt taken.
    output logic [rtsp_pkg::RTSP_TW-1:0] data  // Load value.
);
    // Everything idles low and moves only on falling edges.
    initial begin
        w2 = 4'h0;
        ld2 = 1'h0;
        sk2 = 1'h0;
        ack2 = 1'h0;
        ld1 = 1'h0;
        wr1 = 1'h0;
        sk1 = 1'h0;
        ack1 = 1'h0;
        data = 8'h00;
    end
    // First timer load (r low) or reload-only write (r high); the bench
    // halts that timer beforehand, so no count races the write.
    task automatic load1(input logic [7:0] v, input logic r);
        @(negedge mclk);
        data = v;
        if (r) wr1 = 1'h1;
        else ld1 = 1'h1;
        @(negedge mclk);
        ld1 = 1'h0;
        wr1 = 1'h0;
    endtask
    // Control write: bit 3 runs, bit 2 auto-stop, bits 1:0 source.
    task automatic cfg2(input logic [3:0] v);
        @(negedge mclk);
        w2 = v;
    endtask
    // Halting in the same edge keeps the load from racing a count.
    task automatic load2(input logic [7:0] v);
        cfg2({1'h0, w2[2:0]});
        data = v;
        ld2 = 1'h1;
        @(negedge mclk);
        ld2 = 1'h0;
    endtask
    // Source changes only while stopped, run is set last.
    task automatic run2(input logic [1:0] s);
        cfg2({2'h0, s});
        cfg2({2'h2, s});
    endtask
    // One-cycle skip test (s high) or interrupt acknowledge, for the first
    // timer when one is high and for the second otherwise.
    task automatic pulse(input logic s, input logic one);
        @(negedge mclk);
        if (s && one) sk1 = 1'h1;
        else if (s) sk2 = 1'h1;
        else if (one) ack1 = 1'h1;
        else ack2 = 1'h1;
        @(negedge mclk);
        sk1 = 1'h0;
        sk2 = 1'h0;
        ack1 = 1'h0;
        ack2 = 1'h0;
    endtask
endmodule // rtsp_cpu_model
`default_nettype wire

// ### reload_timer_pair_with_start_sync_tb.sv
// Self-checking bench for the timer unit.
`timescale 1ns/1ps
`default_nettype none
module reload_timer_pair_with_start_sync_tb;
    import rtsp_pkg::*;
    logic mclk = 1'h0, arst_n = 1'h0, ip = 1'h1, cp = 1'h1;
    logic [3:0] w1 = 4'h0, w2;
    logic [2:0] i1 = 3'h0;
    logic [1:0] w6 = 2'h0, v1 = 2'h0;
    logic ld2, sk2, ack2, f2, q2, sk, po, oe, sy;
    logic ld1, wr1, sk1, ack1, f1, q1;
    logic [7:0] dat, c1, c2, xs = 8'h06;
    localparam int GAP_MAX = 600;
    int mismatches = 0, comparisons = 0, c;
    always #4 mclk = ~mclk;
    rtsp_cpu_model i_cpu (.mclk(mclk), .w2(w2), .ld2(ld2), .sk2(sk2),
        .ack2(ack2), .ld1(ld1), .wr1(wr1), .sk1(sk1), .ack1(ack1),
        .data(dat));
    // The first reload is written only while that timer is halted, so the
    // reload-write underflow hazard cannot arise.
    rtsp_timer_unit i_dut (.mclk(mclk), .arst_n(arst_n),
        .first_timer_control_register(w1),
        .second_timer_control_register(w2), .pin_function_register(w6),
        .interrupt_pin_control_register(i1), .interrupt_select_register(v1),
        .load_first_timer_and_reload_instr(ld1),
        .write_first_reload_instr(wr1),
        .load_second_timer_and_reload_instr(ld2), .instr_data(dat),
        .skip_on_first_timer_flag(sk1), .skip_on_second_timer_flag(sk2),
        .first_timer_int_ack(ack1), .second_timer_int_ack(ack2),
        .int_pin(ip), .counter_pin_in(cp), .first_timer_count(c1),
        .second_timer_count(c2), .first_timer_underflow_flag(f1),
        .second_timer_underflow_flag(f2), .first_timer_irq(q1),
        .second_timer_irq(q2), .skip_next(sk), .counter_pin_out(po),
        .counter_pin_oe(oe), .sync_active(sy));
    // Value comparison.
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Cycle count comparison.
    task automatic chk_cyc(input int g, input int e);
        comparisons++;
        if (g != e) begin
            mismatches++;
            $display("unexpected at %0t: %0d cycles, want %0d", $time, g, e);
        end
    endtask
    // Next value of the bench's random sequence.
    function automatic logic [7:0] xorshift(input logic [7:0] x);
        logic [7:0] y;
        y = x ^ (x << 3);
        y = y ^ (y >> 5);
        return y ^ (y << 4);
    endfunction
    // Output toggle period: n plus one count pulses of d cycles each.
    function automatic int period(input int n, input int d);
        return (n + 1) * d;
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    // Cycles until the counter pin output changes, bounded.
    task automatic gap(output int n);
        logic p;
        p = po;
        n = 0;
        while (po === p && n < GAP_MAX) begin
            @(negedge mclk);
            n++;
        end
    endtask
    // Skip answer may land in either of the two cycles after the strobe.
    task automatic skip_chk(input logic one, input logic e);
        logic s;
        i_cpu.pulse(1'h1, one);
        s = sk;
        @(negedge mclk);
        chk(s | sk, e);
    endtask
    task automatic stop_test;
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        cyc(30000);
        mismatches++;
        stop_test();
    end
    initial begin
        cyc(10);
        arst_n = 1'h1;
        chk({c2[3:0], f2, sy, po, oe}, 8'h00);
        chk({c1[6:0], f1}, 8'h00);
        // Divide ratios: both end values, then random ones.
        w6 = 2'h3;
        for (int k = 0; k < 5; k++) begin
            xs = xorshift(xs);
            i_cpu.load2(k == 0 ? 8'h00 : k == 1 ? 8'hff : xs);
            chk(c2, k == 0 ? 8'h00 : k == 1 ? 8'hff : xs);
            i_cpu.run2(RTSP_SRC_SYSCLK);
            gap(c);
            gap(c);
            chk_cyc(c, period(k == 0 ? 0 : k == 1 ? 255 : xs, 1));
            chk(f2, 1'h1);
        end
        chk(oe, 1'h1);
        // Falling counter pin edges are the only counted ones.
        i_cpu.load2(8'h00);
        i_cpu.run2(RTSP_SRC_PIN);
        skip_chk(1'h0, 1'h1);
        v1 = 2'h2;
        cp = 1'h0;
        cyc(8);
        chk({f2, q2}, 2'h3);
        i_cpu.pulse(1'h0, 1'h0);
        cyc(2);
        chk({f2, q2}, 2'h0);
        cp = 1'h1;
        cyc(8);
        chk(f2, 1'h0);
        skip_chk(1'h0, 1'h0);
        // Start sync per edge mode: falling first, then back up.
        w1 = 4'h1;
        for (int k = 0; k < 3; k++) begin
            i1 = 3'h0;
            cyc(8);
            i1 = k == 0 ? 3'h1 : k == 1 ? 3'h5 : 3'h3;
            ip = 1'h0;
            cyc(8);
            chk(sy, k != 1);
            ip = 1'h1;
            cyc(8);
            chk(sy, 1'h1);
        end
        w1 = 4'hb;
        cyc(40);
        chk(sy, 1'h1);
        i_cpu.cfg2(4'h4);
        cyc(40);
        chk(sy, 1'h0);
        // First timer: halt, load, reload-only write, then count and flag.
        w1 = 4'h0;
        w6 = 2'h1;
        i_cpu.load1(8'h05, 1'h0);
        chk(c1, 8'h05);
        i_cpu.load1(8'h02, 1'h1);
        chk(c1, 8'h05);
        skip_chk(1'h1, 1'h1);
        chk(f1, 1'h0);
        w1 = 4'ha;
        gap(c);
        gap(c);
        chk_cyc(c, period(2, RTSP_PRESC_DIV_FAST));
        chk({f1, q1}, 2'h2);
        w1 = 4'h0;
        v1 = 2'h3;
        cyc(3);
        chk({f1, q1}, 2'h3);
        i_cpu.pulse(1'h0, 1'h1);
        chk({f1, q1}, 2'h0);
        // Second timer on the slow prescaler, then the prescaler stopped.
        w1 = 4'hc;
        w6 = 2'h3;
        i_cpu.load2(8'h01);
        i_cpu.run2(RTSP_SRC_PRESC);
        gap(c);
        gap(c);
        chk_cyc(c, period(1, RTSP_PRESC_DIV_SLOW));
        w1 = 4'h0;
        cyc(4);
        gap(c);
        chk_cyc(c, GAP_MAX);
        stop_test();
    end
endmodule // reload_timer_pair_with_start_sync_tb
`default_nettype wire
